// >>> hdl/skew_recovery_pkg.sv
/*
  Constants for the skew and recovery frequency register bank:
  byte offsets, field positions, reset values and skew encodings.
  Assumes the serial interface presents one byte access per strobe.
*/
package skew_recovery_pkg;

  localparam logic [7:0] OFS_OUTPUT_SKEW_CONTROL = 8'h0A;
  localparam logic [7:0] OFS_RECOVERY_N_VALUE    = 8'h0B;
  localparam logic [7:0] OFS_RECOVERY_M_AND_SRC  = 8'h0C;

  localparam logic [7:0] RST_OUTPUT_SKEW_CONTROL = 8'h00;
  localparam logic [7:0] RST_RECOVERY_N_VALUE    = 8'h00;
  localparam logic [7:0] RST_RECOVERY_M_AND_SRC  = 8'h00;

  // Writable bits of the skew byte; bits 4:2 are reserved
  localparam logic [7:0] SKEW_WRITE_MASK = 8'hE3;

  localparam int CPU_PAIR_SKEW_MSB = 7;
  localparam int CPU_PAIR_SKEW_LSB = 5;
  localparam int DIFF_SKEW_MSB     = 1;
  localparam int DIFF_SKEW_LSB     = 0;
  localparam int SRC_SEL_BIT       = 7;
  localparam int M_FIELD_MSB       = 6;

  // Skew applied by each code, in picoseconds
  localparam int CPU_PAIR_SKEW_PS [8] = '{0, -150, -300, -450, 150, 300, 450, 600};
  localparam int DIFF_SKEW_PS     [4] = '{0, -150, 150, 300};

  // Frequency source that drives the CPU outputs
  typedef enum logic [2:0] {
    SRC_NORMAL   = 3'b001,
    SRC_RECOVERY = 3'b010,
    SRC_LOCKED   = 3'b100
  } mode_t;

endpackage

// >>> hdl/recovery_select.sv
/*
  Chooses the recovery frequency source and the clock ratio source.
  Assumes the strap code was latched at power-up by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
module recovery_select
  import skew_recovery_pkg::*;
(
  // Selection controls
  input  wire logic       recovery_source_sel,
  input  wire logic       ratio_override,
  // Candidate values
  input  wire logic [4:0] strap_freq_code,
  input  wire logic [4:0] sw_ratio_code,
  input  wire logic [7:0] recovery_n_divider,
  input  wire logic [6:0] recovery_m_divider,
  // Results
  output logic            use_programmed_nm,
  output logic      [4:0] ratio_code,
  output logic      [7:0] sel_n,
  output logic      [6:0] sel_m
);

  always_comb begin
    use_programmed_nm = recovery_source_sel;
    ratio_code        = ratio_override ? sw_ratio_code : strap_freq_code;
    sel_n             = recovery_source_sel ? recovery_n_divider : 8'h00;
    sel_m             = recovery_source_sel ? recovery_m_divider : 7'h00;
  end

endmodule
`default_nettype wire

// >>> hdl/skew_recovery_regs.sv
/*
  Skew control and recovery frequency register bank of the clock
  synthesizer, with recovery lock handling after a watchdog time-out.
  Assumes the serial bus slave gives single-cycle byte read/write strobes
  and the watchdog counter supplies a one-cycle expiry pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module skew_recovery_regs
  import skew_recovery_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Byte register access from the serial interface
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  // Watchdog interface
  input  wire logic       watchdog_expired,
  input  wire logic       watchdog_enable,
  input  wire logic       timeout_reset_enable,
  input  wire logic       timeout_flag_clear,
  output logic            timeout_flag,
  output logic            system_reset_pulse,
  // Frequency sources
  input  wire logic [4:0] strap_freq_code,
  input  wire logic [4:0] sw_ratio_code,
  input  wire logic       ratio_override,
  // Controls toward the synthesizer
  output logic      [2:0] cpu_pair_skew_sel,
  output logic      [1:0] diff_cpu_skew_sel,
  output logic      [4:0] ratio_code,
  output logic      [7:0] active_n,
  output logic      [6:0] active_m,
  output logic            use_programmed_nm,
  output logic            recovery_active,
  output logic            freq_change_pulse
);

  typedef struct packed {
    logic [7:0] skew;
    logic [7:0] rec_n;
    logic [7:0] rec_m_src;
    logic [7:0] rdata;
    logic       hit;
    mode_t      mode;
    logic       flag;
    logic       rst_pulse;
    logic       chg_pulse;
    logic [7:0] act_n;
    logic [6:0] act_m;
    logic       act_prog;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic       sel_prog;
  logic [4:0] sel_ratio;
  logic [7:0] sel_n;
  logic [6:0] sel_m;

  recovery_select u_sel (
    .recovery_source_sel (st_r.rec_m_src[SRC_SEL_BIT]),
    .ratio_override      (ratio_override),
    .strap_freq_code     (strap_freq_code),
    .sw_ratio_code       (sw_ratio_code),
    .recovery_n_divider  (st_r.rec_n),
    .recovery_m_divider  (st_r.rec_m_src[M_FIELD_MSB:0]),
    .use_programmed_nm   (sel_prog),
    .ratio_code          (sel_ratio),
    .sel_n               (sel_n),
    .sel_m               (sel_m)
  );

  always_comb begin
    st_nxt           = st_r;
    st_nxt.rst_pulse = 1'b0;
    st_nxt.chg_pulse = 1'b0;
    st_nxt.hit       = 1'b0;
    st_nxt.rdata     = 8'h00;

    if (reg_wr) begin
      unique case (reg_addr)
        OFS_OUTPUT_SKEW_CONTROL: begin
          st_nxt.skew = reg_wdata & SKEW_WRITE_MASK;
        end
        OFS_RECOVERY_N_VALUE: begin
          st_nxt.rec_n = reg_wdata;
        end
        OFS_RECOVERY_M_AND_SRC: begin
          st_nxt.rec_m_src = reg_wdata;
        end
        default: begin
        end
      endcase
    end

    if (reg_rd) begin
      unique case (reg_addr)
        OFS_OUTPUT_SKEW_CONTROL: begin
          st_nxt.rdata = st_r.skew & SKEW_WRITE_MASK;
          st_nxt.hit   = 1'b1;
        end
        OFS_RECOVERY_N_VALUE: begin
          st_nxt.rdata = st_r.rec_n;
          st_nxt.hit   = 1'b1;
        end
        OFS_RECOVERY_M_AND_SRC: begin
          st_nxt.rdata = st_r.rec_m_src;
          st_nxt.hit   = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Clear loses to a simultaneous expiry so no time-out goes unseen
    if (timeout_flag_clear) begin
      st_nxt.flag = 1'b0;
    end
    if (watchdog_expired) begin
      st_nxt.flag = 1'b1;
    end

    unique case (st_r.mode)
      SRC_NORMAL: begin
        if (watchdog_expired) begin
          st_nxt.mode      = SRC_LOCKED;
          st_nxt.rst_pulse = timeout_reset_enable;
          st_nxt.chg_pulse = 1'b1;
          st_nxt.act_prog  = sel_prog;
          st_nxt.act_n     = sel_n;
          st_nxt.act_m     = sel_m;
        end
      end
      SRC_LOCKED: begin
        // While locked, register writes are stored but do not move the output
        if (watchdog_expired) begin
          // A further time-out still reports and may reset, and reloads recovery
          st_nxt.rst_pulse = timeout_reset_enable;
          st_nxt.chg_pulse = 1'b1;
          st_nxt.act_prog  = sel_prog;
          st_nxt.act_n     = sel_n;
          st_nxt.act_m     = sel_m;
        end else if (!watchdog_enable) begin
          st_nxt.mode = SRC_RECOVERY;
        end
      end
      SRC_RECOVERY: begin
        // Unlocked after a recovery: programmed N/M writes take effect at once
        if (watchdog_expired) begin
          st_nxt.mode      = SRC_LOCKED;
          st_nxt.rst_pulse = timeout_reset_enable;
          st_nxt.chg_pulse = 1'b1;
          st_nxt.act_prog  = sel_prog;
          st_nxt.act_n     = sel_n;
          st_nxt.act_m     = sel_m;
        end else if (reg_wr && st_r.act_prog &&
                     (reg_addr == OFS_RECOVERY_N_VALUE ||
                      reg_addr == OFS_RECOVERY_M_AND_SRC)) begin
          // Each byte applies alone, so intermediate N/M pairs can appear
          st_nxt.chg_pulse = 1'b1;
          if (reg_addr == OFS_RECOVERY_N_VALUE) begin
            st_nxt.act_n = reg_wdata;
          end else begin
            st_nxt.act_m = reg_wdata[M_FIELD_MSB:0];
          end
        end
      end
      default: begin
        st_nxt.mode = SRC_NORMAL;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r.skew      <= RST_OUTPUT_SKEW_CONTROL;
      st_r.rec_n     <= RST_RECOVERY_N_VALUE;
      st_r.rec_m_src <= RST_RECOVERY_M_AND_SRC;
      st_r.rdata     <= 8'h00;
      st_r.hit       <= 1'b0;
      st_r.mode      <= SRC_NORMAL;
      st_r.flag      <= 1'b0;
      st_r.rst_pulse <= 1'b0;
      st_r.chg_pulse <= 1'b0;
      st_r.act_n     <= 8'h00;
      st_r.act_m     <= 7'h00;
      st_r.act_prog  <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata          = st_r.rdata;
  assign reg_hit            = st_r.hit;
  assign timeout_flag       = st_r.flag;
  assign system_reset_pulse = st_r.rst_pulse;
  assign freq_change_pulse  = st_r.chg_pulse;
  assign cpu_pair_skew_sel  = st_r.skew[CPU_PAIR_SKEW_MSB:CPU_PAIR_SKEW_LSB];
  assign diff_cpu_skew_sel  = st_r.skew[DIFF_SKEW_MSB:DIFF_SKEW_LSB];
  assign ratio_code         = sel_ratio;
  assign active_n           = st_r.act_n;
  assign active_m           = st_r.act_m;
  assign use_programmed_nm  = st_r.act_prog;
  assign recovery_active    = (st_r.mode != SRC_NORMAL);

endmodule
`default_nettype wire

// >>> verif/skew_recovery_regs_chk.sv
/* Port checker for the skew and recovery register bank.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module skew_recovery_regs_chk (
  // Clock, reset, byte access, active N and M
  input wire logic       sys_clk, sys_rst, reg_wr, reg_rd, reg_hit,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, active_n,
  input wire logic [6:0] active_m,
  // Watchdog and synthesizer controls
  input wire logic       watchdog_expired, watchdog_enable, timeout_reset_enable,
  input wire logic       timeout_flag_clear, timeout_flag, system_reset_pulse,
  input wire logic       use_programmed_nm, recovery_active, freq_change_pulse,
  input wire logic [2:0] cpu_pair_skew_sel,
  input wire logic [1:0] diff_cpu_skew_sel
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire skw = reg_wr && reg_addr == 8'h0A;
  sequence s_locked; watchdog_expired ##1 (watchdog_enable && !watchdog_expired); endsequence
  // Two quiet low-enable cycles rule out a pending lock
  sequence s_n_wr; (!watchdog_enable && !watchdog_expired)[*2] ##0
    (recovery_active && use_programmed_nm && reg_wr && reg_addr == 8'h0B); endsequence
  property p_pair; skw |=> cpu_pair_skew_sel == $past(reg_wdata[7:5]); endproperty
  a_pair: assert property (p_pair) else $error("pair skew");
  property p_diff; skw |=> diff_cpu_skew_sel == $past(reg_wdata[1:0]); endproperty
  a_diff: assert property (p_diff) else $error("diff skew");
  property p_rsvd; reg_rd && reg_addr == 8'h0A |=> reg_hit && reg_rdata[4:2] == 3'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");
  property p_exp; watchdog_expired |=> recovery_active && timeout_flag && freq_change_pulse;
  endproperty
  a_exp: assert property (p_exp) else $error("expiry");
  property p_rstg;
    watchdog_expired |=> system_reset_pulse == $past(timeout_reset_enable);
  endproperty
  a_rstg: assert property (p_rstg) else $error("reset gate");
  property p_lock; s_locked |=> $stable(active_n) && $stable(active_m) && !freq_change_pulse;
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_newn; s_n_wr |=> freq_change_pulse && active_n == $past(reg_wdata); endproperty
  a_newn: assert property (p_newn) else $error("n update");
  property p_clr; timeout_flag_clear && !watchdog_expired |=> !timeout_flag; endproperty
  a_clr: assert property (p_clr) else $error("flag clear");
endmodule
bind skew_recovery_regs skew_recovery_regs_chk chk_inst (.sys_clk, .sys_rst, .reg_wr,
  .reg_rd, .reg_hit, .reg_addr, .reg_wdata, .reg_rdata, .active_n, .active_m,
  .watchdog_expired, .watchdog_enable, .timeout_reset_enable, .timeout_flag_clear,
  .timeout_flag, .system_reset_pulse, .use_programmed_nm, .recovery_active,
  .freq_change_pulse, .cpu_pair_skew_sel, .diff_cpu_skew_sel);
`default_nettype wire

// >>> verif/host_model.sv
/* Host model issuing byte reads and writes on the register strobes.
   Assumes strobes are taken on the rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock and read answer
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_hit,
  // Request
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // Released data never keeps the last byte
    reg_wdata <= ~d;
    #1;
  endtask
  // Word write issues the N and M bytes as two separate byte writes
  task automatic wr_word(input logic [7:0] n, input logic [7:0] m);
    wr(8'h0B, n);
    wr(8'h0C, m);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    h = reg_hit;
  endtask
endmodule
`default_nettype wire

// >>> verif/skew_and_recovery_freq_regs_test.sv
/* Bench for the skew and recovery register bank.
   Assumes the host model drives every register access. */
`timescale 1ns/100ps
`default_nettype none
module skew_and_recovery_freq_regs_test
  import skew_recovery_pkg::*;
;
  logic sys_clk = 1'b0, sys_rst = 1'b1, watchdog_expired = 1'b0, watchdog_enable = 1'b1;
  logic timeout_reset_enable = 1'b1, timeout_flag_clear = 1'b0, ratio_override = 1'b0;
  logic [4:0] strap_freq_code = 5'h00, sw_ratio_code = 5'h00, ratio_code;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, active_n, d, n, m;
  logic [6:0] active_m;
  logic [2:0] cpu_pair_skew_sel;
  logic [1:0] diff_cpu_skew_sel;
  logic reg_wr, reg_rd, reg_hit, timeout_flag, system_reset_pulse, h;
  logic use_programmed_nm, recovery_active, freq_change_pulse;
  integer seed = 32'h0A71;
  int n_mismatch = 0, comparisons = 0;
  always #20 sys_clk = ~sys_clk;
  skew_recovery_regs skew_recovery_regs_inst (.sys_clk, .sys_rst, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .reg_hit, .watchdog_expired, .watchdog_enable,
    .timeout_reset_enable, .timeout_flag_clear, .timeout_flag, .system_reset_pulse,
    .strap_freq_code, .sw_ratio_code, .ratio_override, .cpu_pair_skew_sel,
    .diff_cpu_skew_sel, .ratio_code, .active_n, .active_m, .use_programmed_nm,
    .recovery_active, .freq_change_pulse);
  host_model host_model_inst (.sys_clk, .reg_rdata, .reg_hit, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd);
  function automatic logic [7:0] exp_skew(input logic [7:0] v);
    return {v[7:5], 3'h0, v[1:0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic pulse(input logic clr);
    @(posedge sys_clk);
    watchdog_expired <= !clr;
    timeout_flag_clear <= clr;
    @(posedge sys_clk);
    {watchdog_expired, timeout_flag_clear} <= 2'h0;
    #1;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 10; a < 14; a++) begin
      host_model_inst.rd(8'(a), d, h);
      chk(d | 8'(h && a == 13), 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      n = {3'(i), 3'($random(seed)), 2'(i)};
      host_model_inst.wr(OFS_OUTPUT_SKEW_CONTROL, n);
      chk({cpu_pair_skew_sel, 3'h0, diff_cpu_skew_sel}, exp_skew(n));
      host_model_inst.rd(OFS_OUTPUT_SKEW_CONTROL, d, h);
      chk(d, exp_skew(n));
      @(posedge sys_clk);
      ratio_override <= i[0];
      {strap_freq_code, sw_ratio_code} <= 10'($random(seed));
      #1;
      chk(8'(ratio_code), 8'(ratio_override ? sw_ratio_code : strap_freq_code));
    end
    n = 8'($random(seed)) | 8'h01;
    m = 8'($random(seed)) | 8'h01;
    pulse(1'b0);
    chk({timeout_flag, recovery_active, freq_change_pulse, system_reset_pulse,
      use_programmed_nm, 3'h0}, 8'hF0);
    chk(active_n, 8'h00);
    pulse(1'b1);
    chk(8'(timeout_flag), 8'h00);
    // Locked: new dividers are stored, not applied
    host_model_inst.wr_word(n, m | 8'h80);
    chk({active_m, freq_change_pulse}, 8'h00);
    @(posedge sys_clk) watchdog_enable <= 1'b0;
    @(posedge sys_clk) watchdog_enable <= 1'b1;
    timeout_reset_enable <= 1'b0;
    pulse(1'b0);
    chk({active_m, use_programmed_nm}, {m[6:0], 1'b1});
    chk(active_n, n);
    chk(8'(system_reset_pulse), 8'h00);
    @(posedge sys_clk) watchdog_enable <= 1'b0;
    n = n ^ 8'h80;
    host_model_inst.wr(OFS_RECOVERY_N_VALUE, n);
    chk(active_n, n);
    chk({active_m, freq_change_pulse}, {m[6:0], 1'b1});
    // Let the checker finish the update attempt before reset is pulled again
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 10; a < 13; a++) begin
      host_model_inst.rd(8'(a), d, h);
      chk(d, 8'h00);
      chk(8'(h), 8'h01);
    end
    chk({timeout_flag, recovery_active, use_programmed_nm, active_m[4:0]}, 8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
